// [shared/sram_port_map.svh]
// constants of the flow-through synchronous memory port
// assumes: included by bare name from the package and the design files
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

// ==========================================================
// widths
`define ADDR_W 20
`define DATA_W 18
`define LANE_W 9
`define LANES 2
`define BURST_W 2
`define HIGH_ADDR_W 18

// ==========================================================
// fields
`define LANE_LOW_LSB 0
`define LANE_HIGH_LSB 9

// ==========================================================
// write buffer
`define WBUF_DEPTH 8
`define WBUF_W 40

// ==========================================================
// reset values
`define BURST_ORDER_RST 1'b1
`define STEP_RST 2'h0

`endif

// [shared/sram_port_pkg.sv]
// types shared by the memory port design files
// assumes: sram_port_map.svh is on the include path
`include "sram_port_map.svh"
`default_nettype none

package sram_port_pkg;
   // operation latched by the burst-starting load cycle
   typedef enum logic [1:0] {OP_DESELECT, OP_READ, OP_WRITE} burst_op_t;
   typedef logic [`ADDR_W-1:0] word_addr_t;
   typedef logic [`DATA_W-1:0] word_data_t;
   typedef logic [`LANES-1:0] lane_mask_t;
   typedef logic [`BURST_W-1:0] burst_pos_t;
endpackage

`default_nettype wire

// [testbench/flowthrough_sync_sram_port_bench.sv]
// self-checking bench for the flow-through memory port
// assumes: package, design, host model and checker compiled before it
`default_nettype none

module flowthrough_sync_sram_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sram_port_pkg::*;
   logic clk, rst, hold_n, sf_n, ss, st_n, adv, rnw, lw_n, hw_n, oe_n, ord, slp, oe;
   logic oe_set, ord_set, slp_set, chk_on, exp_oe, pend;
   logic [1:0] op, step;
   logic [5:0] tab [$];
   word_addr_t addr, base, cur, pa, wa;
   word_data_t din, dout, exp_do, pd, old;
   lane_mask_t pl;
   word_data_t mem [word_addr_t];
   int seed = 74278;
   int fail_count = 0;
   int n_checks = 0;
   // ====
   // design, host and clock
   flowthrough_sync_sram_port u_dut (
      .CLK(clk), .RST(rst), .CLOCK_HOLD_N(hold_n), .ADDR(addr),
      .SELECT_FIRST_N(sf_n), .SELECT_SECOND(ss), .SELECT_THIRD_N(st_n),
      .ADVANCE_OR_LOAD(adv), .READ_NOT_WRITE(rnw), .LANE_LOW_WRITE_N(lw_n),
      .LANE_HIGH_WRITE_N(hw_n), .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_SEL(ord),
      .SLEEP_REQUEST(slp), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe));
   sram_host_model u_host (
      .clk(clk), .clock_hold_n(hold_n), .addr(addr), .select_first_n(sf_n),
      .select_second(ss), .select_third_n(st_n), .advance_or_load(adv),
      .read_not_write(rnw), .lane_low_write_n(lw_n), .lane_high_write_n(hw_n),
      .data_in(din));
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // ====
   // compare and verdict
   task automatic check(input string what, input logic [17:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one bus cycle; checks the cycle before, then models this one
   task automatic cyc(input logic hold, ld, sel, rd, input word_addr_t a,
      input lane_mask_t ln);
      logic [31:0] r;
      r = $random(seed);
      if (!ld) begin
         {sel, rd} = r[19:18];
         a = ~a;
      end
      u_host.drive(hold, ld, sel, rd, a, ln, r[17:0]);
      {oe_n, ord, slp} <= {oe_set, ord_set, slp_set};
      @(negedge clk);
      if (chk_on) check("drive enable", {17'h0, oe}, {17'h0, exp_oe});
      if (chk_on && exp_oe) check("read data", dout, exp_do);
      if (!hold) begin
         old = mem.exists(pa) ? mem[pa] : '0;
         if (pend && !slp) mem[pa] = {pl[1] ? old[17:9] : pd[17:9], pl[0] ? old[8:0] : pd[8:0]};
         pend = 1'b0;
         if (slp) op = 2'h0;
         else if (ld) begin
            op = !sel ? 2'h0 : rd ? 2'h1 : 2'h2;
            base = a;
            step = 2'h0;
         end else step++;
         cur = {base[19:2], ord ? base[1:0] ^ step : base[1:0] + step};
         if (op == 2'h2 && ln != 2'h3) {pend, pa, pl, pd} = {1'b1, cur, ln, r[17:0]};
         exp_oe = op == 2'h1 && !oe_n;
         if (op == 2'h1) exp_do = mem[cur];
      end
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b1, 1'b0, 1'b1, '0, 2'h3);
   endtask
   task automatic run;
      foreach (tab[i]) cyc(tab[i][5], tab[i][4], tab[i][3], tab[i][2], wa, tab[i][1:0]);
   endtask
   // ====
   // main sequence
   initial begin
      rst = 1'b1;
      {oe_set, ord_set, slp_set, chk_on, pend, exp_oe, op, step} = 10'h100;
      {oe_n, ord, slp, base, pa} = {3'b010, 40'h0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("drive after reset", {17'h0, oe}, 18'h0);
      idle(3);
      chk_on = 1'b1;
      // full write then read burst, wrapping, in both orders
      for (int o = 1; o >= 0; o--) begin
         ord_set = o[0];
         idle(3);
         wa = $random(seed);
         tab = '{6'h18, 6'h00, 6'h00, 6'h00, 6'h00, 6'h1f, 6'h03, 6'h03, 6'h03, 6'h03};
         run();
      end
      // lane writes, abort, hold in read and write, deselect then advance
      tab = '{6'h1a, 6'h19, 6'h1b, 6'h1f, 6'h3f, 6'h3f, 6'h03, 6'h18, 6'h20, 6'h1f,
         6'h13, 6'h03, 6'h03};
      run();
      // reads with output enable off
      oe_set = 1'b1;
      idle(3);
      tab = '{6'h1f, 6'h03};
      run();
      oe_set = 1'b0;
      idle(3);
      // sleep entered on an idle bus; writes while asleep are lost
      slp_set = 1'b1;
      idle(3);
      tab = '{6'h18, 6'h00, 6'h1f};
      run();
      // only deselects and reads while waking
      slp_set = 1'b0;
      idle(3);
      tab = '{6'h1f, 6'h03};
      run();
      idle(2);
      final_report();
   end
   // hang guard
   initial begin
      #50us;
      fail_count++;
      final_report();
   end
endmodule // flowthrough_sync_sram_port_bench

`default_nettype wire

// [testbench/sram_host_model.sv]
// host controller model: drives the synchronous bus pins
// assumes: the bench calls drive once per clock edge
`default_nettype none

module sram_host_model (
   input wire logic clk, // clock
   output var logic clock_hold_n, // edge mask
   output sram_port_pkg::word_addr_t addr, // address
   output var logic select_first_n, // select
   output var logic select_second, // select
   output var logic select_third_n, // select
   output var logic advance_or_load, // advance
   output var logic read_not_write, // direction
   output var logic lane_low_write_n, // lane
   output var logic lane_high_write_n, // lane
   output sram_port_pkg::word_data_t data_in // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   import sram_port_pkg::*;
   logic wr_q, pend_q; // burst is a write, data phase due
   word_data_t pend_d_q; // data for that phase
   logic [1:0] dsel_q; // which select drops on deselect
   // ====
   // idle deselected bus from time zero
   initial begin
      {clock_hold_n, select_first_n, select_second, select_third_n} = 4'h1;
      {advance_or_load, read_not_write, lane_low_write_n, lane_high_write_n} = 4'h7;
      addr = '0;
      data_in = '0;
      {wr_q, pend_q, dsel_q, pend_d_q} = '0;
   end
   // one bus cycle, launched just after a rising edge
   task automatic drive(input logic hold, ld, sel, rd, input word_addr_t a,
      input lane_mask_t ln, input word_data_t d);
      @(posedge clk);
      clock_hold_n <= hold;
      if (!hold) begin
         addr <= a;
         advance_or_load <= !ld;
         read_not_write <= rd;
         {lane_high_write_n, lane_low_write_n} <= ln;
         {select_first_n, select_second, select_third_n} <=
            sel ? 3'b010 : 3'b010 ^ (3'b001 << dsel_q);
         dsel_q = (dsel_q == 2'h2) ? 2'h0 : dsel_q + 2'h1;
         // data follows its command by one cycle
         data_in <= pend_q ? pend_d_q : ~data_in;
         if (ld) wr_q = sel && !rd;
         pend_q = wr_q;
         pend_d_q = d;
      end
   endtask
endmodule // sram_host_model

`default_nettype wire

// [testbench/sram_port_checker.sv]
// checker for the memory port, sees only the top-level pins
// assumes: bound into flowthrough_sync_sram_port, one clock domain
`default_nettype none

module sram_port_checker (
   input wire logic CLK, // clock
   input wire logic RST, // reset
   input wire logic CLOCK_HOLD_N, // edge mask
   input wire sram_port_pkg::word_addr_t ADDR, // address
   input wire logic SELECT_FIRST_N, // select
   input wire logic SELECT_SECOND, // select
   input wire logic SELECT_THIRD_N, // select
   input wire logic ADVANCE_OR_LOAD, // advance
   input wire logic READ_NOT_WRITE, // direction
   input wire logic LANE_LOW_WRITE_N, // lane
   input wire logic LANE_HIGH_WRITE_N, // lane
   input wire logic OUTPUT_ENABLE_N, // enable
   input wire logic BURST_ORDER_SEL, // order
   input wire logic SLEEP_REQUEST, // sleep
   input wire sram_port_pkg::word_data_t DATA_IN, // data in
   input wire sram_port_pkg::word_data_t DATA_OUT, // data out
   input wire logic DATA_OE // drive
);
   timeunit 1ns;
   timeprecision 1ps;
   import sram_port_pkg::*;
   // ====
   // decoded bus cycles
   logic go, ld, sel;
   assign go = !CLOCK_HOLD_N;
   assign ld = go && !ADVANCE_OR_LOAD;
   assign sel = !SELECT_FIRST_N && SELECT_SECOND && !SELECT_THIRD_N;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ====
   // output driver checks
   chk_reset_float: assert property ($fell(RST) |-> !DATA_OE)
      else $error("pins driven after reset");
   chk_hold_out: assert property (CLOCK_HOLD_N |=> $stable(DATA_OUT))
      else $error("read data moved on a held edge");
   chk_hold_drive: assert property (CLOCK_HOLD_N && DATA_OE && !OUTPUT_ENABLE_N
      && !SLEEP_REQUEST |=> DATA_OE)
      else $error("drive dropped on a held edge");
   chk_desel_float: assert property (ld && !sel |=> !DATA_OE)
      else $error("pins driven after deselect");
   chk_write_float: assert property (ld && sel && !READ_NOT_WRITE |=> !DATA_OE)
      else $error("pins driven in a write");
   chk_adv_desel: assert property (ld && !sel ##1 go && ADVANCE_OR_LOAD
      |=> !DATA_OE)
      else $error("advance after deselect drove pins");
   chk_oe_float: assert property ((OUTPUT_ENABLE_N && go)[*5] |-> !DATA_OE)
      else $error("pins driven with enable off");
   chk_sleep_float: assert property (SLEEP_REQUEST[*5] |-> !DATA_OE)
      else $error("pins driven while asleep");
   chk_read_drive: assert property ((go && !OUTPUT_ENABLE_N && !SLEEP_REQUEST)[*4]
      ##0 ld && sel && READ_NOT_WRITE |=> DATA_OE)
      else $error("read did not drive pins");
   // main scenarios reached
   cover property (ld && sel && READ_NOT_WRITE ##1 DATA_OE);
   cover property (CLOCK_HOLD_N && DATA_OE);
   cover property (ld && sel && !READ_NOT_WRITE ##1 go && ADVANCE_OR_LOAD);
endmodule // sram_port_checker

bind flowthrough_sync_sram_port sram_port_checker u_chk (
   .CLK(CLK), .RST(RST), .CLOCK_HOLD_N(CLOCK_HOLD_N), .ADDR(ADDR),
   .SELECT_FIRST_N(SELECT_FIRST_N), .SELECT_SECOND(SELECT_SECOND),
   .SELECT_THIRD_N(SELECT_THIRD_N), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
   .READ_NOT_WRITE(READ_NOT_WRITE), .LANE_LOW_WRITE_N(LANE_LOW_WRITE_N),
   .LANE_HIGH_WRITE_N(LANE_HIGH_WRITE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
   .BURST_ORDER_SEL(BURST_ORDER_SEL), .SLEEP_REQUEST(SLEEP_REQUEST),
   .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));

`default_nettype wire

// [verilog/flowthrough_sync_sram_port.sv]
// synchronous bus port of a flow-through late-write static memory
// assumes: the host drives all synchronous pins on CLK; output enable,
// burst order select and sleep request arrive asynchronously
// assumes: the data pins are split into an input side and an output side
// with a drive flag; the pad that joins them sits outside this block
//
// Contract
// R1 - only enable, order, sleep act unclocked
// R2 - clock hold freezes everything that edge
// R3 - address loads on load with all selects
// R4 - inactive select on load deselects, hi-Z
// R5 - advance ignores pins, steps burst counter
// R6 - direction on load picks read or write
// R7 - two lane write enables gate lanes
// R8 - drive data only selected with enable
// R9 - order high: interleaved, start xor step
// R10 - order low: linear, start plus step
// R11 - two-bit counter wraps every fourth cycle
// R12 - burst keeps op latched at load
// R13 - advance after deselect stays deselected
// R14 - dummy read floats; all-off write aborts
// R15 - drivers off during write cycles
// R16 - hold keeps read driven, write floating
// R17 - data floats from power-up
// R18 - sleep deselects, floats, retains data
// R19 - host finishes operations before sleep
// R20 - host avoids writes leaving sleep
// R21 - write data one cycle after command
// R22 - read data in the following cycle
`include "sram_port_map.svh"
`default_nettype none

module flowthrough_sync_sram_port (
   input wire logic CLK, // clock
   input wire logic RST, // async reset, active high
   input wire logic CLOCK_HOLD_N, // high masks the clock edge
   input wire sram_port_pkg::word_addr_t ADDR, // word address
   input wire logic SELECT_FIRST_N, // select, active low
   input wire logic SELECT_SECOND, // select, active high
   input wire logic SELECT_THIRD_N, // select, active low
   input wire logic ADVANCE_OR_LOAD, // high advance, low load
   input wire logic READ_NOT_WRITE, // high read, low write
   input wire logic LANE_LOW_WRITE_N, // low lane write enable
   input wire logic LANE_HIGH_WRITE_N, // high lane write enable
   input wire logic OUTPUT_ENABLE_N, // async output enable
   input wire logic BURST_ORDER_SEL, // high interleaved, low linear
   input wire logic SLEEP_REQUEST, // async power-down
   input wire sram_port_pkg::word_data_t DATA_IN, // data pins, input side
   output sram_port_pkg::word_data_t DATA_OUT, // data pins, output side
   output logic DATA_OE // data pins driven
);
   import sram_port_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic oe_meta; // synchroniser stage one
      logic oe_s; // synchronised output enable
      logic order_meta;
      logic order_s;
      logic sleep_meta;
      logic sleep_s;
      burst_op_t op; // operation of current burst
      logic [`HIGH_ADDR_W-1:0] addr_hi; // upper address bits
      burst_pos_t start; // starting low address bits
      burst_pos_t step; // burst step count
      logic rd_cycle; // read data phase this cycle
      logic wr_pend; // write data expected next edge
      word_addr_t wr_addr;
      lane_mask_t wr_lanes;
      word_data_t dout;
      logic drive;
   } port_state_t;

   port_state_t st_q, st_d;

   logic sleeping, held, push_need, advance_edge, selected;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready, head_pop;
   logic [`WBUF_W-1:0] fifo_in_data, fifo_out_data;
   word_addr_t head_addr, addr_n;
   lane_mask_t head_lanes;
   word_data_t head_data, mem_rd, rd_merged;
   logic load_cycle, load_sel, load_read, adv_step;
   logic [`HIGH_ADDR_W-1:0] nxt_hi;
   burst_pos_t nxt_start, nxt_step, nxt_low;

   // ==========================================================
   // functions
   // low address bits of a burst step, in the chosen order
   function automatic burst_pos_t burst_offset(input burst_pos_t start,
                                               input burst_pos_t step,
                                               input logic interleaved);
      // R9 interleaved sequence
      if (interleaved) begin
         return start ^ step;
      end
      // R10 linear sequence
      return burst_pos_t'(start + step);
   endfunction

   // overlay the enabled lanes of a write onto a word
   function automatic word_data_t lane_merge(input word_data_t base,
                                             input lane_mask_t lanes,
                                             input word_data_t wdata);
      word_data_t r;
      r = base;
      if (lanes[0]) begin
         r[`LANE_LOW_LSB +: `LANE_W] = wdata[`LANE_LOW_LSB +: `LANE_W];
      end
      if (lanes[1]) begin
         r[`LANE_HIGH_LSB +: `LANE_W] = wdata[`LANE_HIGH_LSB +: `LANE_W];
      end
      return r;
   endfunction

   // ==========================================================
   // write buffer and array
   // a write carries its address and lanes one edge ahead of its data;
   // the buffer holds the completed word until the array may take it,
   // so a read right behind a write never waits for a dead cycle
   assign head_addr = fifo_out_data[`WBUF_W-1 -: `ADDR_W];
   assign head_lanes = fifo_out_data[`DATA_W +: `LANES];
   assign head_data = fifo_out_data[`DATA_W-1:0];
   assign fifo_in_data = {st_q.wr_addr, st_q.wr_lanes, DATA_IN};

   // R16 no array write on a held edge; R18 contents retained in sleep
   assign fifo_out_ready = !held && !sleeping;
   assign head_pop = fifo_out_valid && fifo_out_ready;

   wbuf_fifo #(
      .WIDTH(`WBUF_W),
      .DEPTH(`WBUF_DEPTH)
   ) u_wbuf (
      .CLK(CLK),
      .RST(RST),
      .in_valid(push_need && advance_edge),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   sram_core_array u_array (
      .CLK(CLK),
      .wr_en(head_pop),
      .wr_addr(head_addr),
      .wr_lanes(head_lanes),
      .wr_data(head_data),
      .rd_addr(addr_n),
      .rd_data(mem_rd)
   );

   // ==========================================================
   // edge qualification
   // R1 synchronous pins are used as sampled on this edge
   assign sleeping = st_q.sleep_s;
   assign held = CLOCK_HOLD_N;
   // R14 an aborted write (no lanes) needs no buffer slot
   assign push_need = st_q.wr_pend && (st_q.wr_lanes != '0);
   // R2 a held edge moves only the synchronisers, the drive flag and what sleep clears; a full buffer stalls the same way
   assign advance_edge = !held && !sleeping && !(push_need && !fifo_in_ready);
   // R4 all three selects must be active
   assign selected = !SELECT_FIRST_N && SELECT_SECOND && !SELECT_THIRD_N;

   // ==========================================================
   // command decode
   // R3 R6 a selected load starts a burst in the sampled direction
   assign load_cycle = !ADVANCE_OR_LOAD;
   assign load_sel = load_cycle && selected;
   assign load_read = load_sel && READ_NOT_WRITE;
   // R5 R13 an advance steps only inside a live burst
   assign adv_step = !load_cycle && (st_q.op != OP_DESELECT);

   // ==========================================================
   // next burst address
   // worked out from the registered state and the pins only, so the
   // array read never depends on the next-state copy of the state
   always_comb begin
      nxt_hi = st_q.addr_hi;
      nxt_start = st_q.start;
      nxt_step = st_q.step;
      if (load_sel) begin
         // R3 fresh address, counter back to zero
         nxt_hi = ADDR[`ADDR_W-1:`BURST_W];
         nxt_start = ADDR[`BURST_W-1:0];
         nxt_step = `STEP_RST;
      end else if (adv_step) begin
         // R11 two-bit counter wraps by itself after four steps
         nxt_step = burst_pos_t'(st_q.step + 1'b1);
      end
   end

   // R9 R10 low bits follow the synchronised order select
   assign nxt_low = burst_offset(nxt_start, nxt_step, st_q.order_s);
   assign addr_n = {nxt_hi, nxt_low};

   // read data with any write still in flight forwarded over it
   // the buffer head lands in the array this edge, and the word in its
   // data phase has not reached the buffer yet, so both are laid over
   always_comb begin
      rd_merged = mem_rd;
      if (head_pop && head_addr == addr_n) begin
         rd_merged = lane_merge(rd_merged, head_lanes, head_data);
      end
      if (push_need && st_q.wr_addr == addr_n) begin
         rd_merged = lane_merge(rd_merged, st_q.wr_lanes, DATA_IN);
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      // asynchronous pins pass two flip-flops
      st_d.oe_meta = !OUTPUT_ENABLE_N;
      st_d.oe_s = st_q.oe_meta;
      st_d.order_meta = BURST_ORDER_SEL;
      st_d.order_s = st_q.order_meta;
      st_d.sleep_meta = SLEEP_REQUEST;
      st_d.sleep_s = st_q.sleep_meta;
      if (advance_edge) begin
         st_d.wr_pend = 1'b0;
         st_d.rd_cycle = 1'b0;
         if (load_cycle) begin
            if (load_sel) begin
               // R3 fresh address on a selected load
               st_d.addr_hi = nxt_hi;
               st_d.start = nxt_start;
               st_d.step = nxt_step;
               // R6 direction chosen at load only
               st_d.op = load_read ? OP_READ : OP_WRITE;
            end else begin
               // R4 load with an inactive select
               st_d.op = OP_DESELECT;
            end
         end else if (adv_step) begin
            // R5 R11 R12 step the two-bit counter, op unchanged
            st_d.step = nxt_step;
         end
         // R13 advance after deselect keeps op deselected
         if (st_d.op == OP_WRITE) begin
            // R7 R21 lanes and address now, data next edge
            st_d.wr_pend = 1'b1;
            st_d.wr_addr = addr_n;
            st_d.wr_lanes = ~{LANE_HIGH_WRITE_N, LANE_LOW_WRITE_N};
         end
         if (st_d.op == OP_READ) begin
            // R22 data registered for the following cycle
            st_d.rd_cycle = 1'b1;
            st_d.dout = rd_merged;
         end
      end
      if (sleeping) begin
         // R18 deselect; a pending read or write data phase is dropped, a buffered word waits
         // the host must have let pending work finish before this;
         // stored words stay, since the array is never cleared
         st_d.op = OP_DESELECT;
         st_d.rd_cycle = 1'b0;
         st_d.wr_pend = 1'b0;
      end
      // R8 R14 R15 R16 drive only a read cycle with enable on
      st_d.drive = st_d.rd_cycle && st_d.oe_s && !st_d.sleep_s;
   end

   // ==========================================================
   // state register
   // R17 drivers off from reset
   // reset floats the pins and forces a deselect; the order select
   // starts as interleaved, the level its pull-up gives when left open
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_q <= '0;
         st_q.op <= OP_DESELECT;
         st_q.order_meta <= `BURST_ORDER_RST;
         st_q.order_s <= `BURST_ORDER_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign DATA_OUT = st_q.dout;
   assign DATA_OE = st_q.drive;
endmodule // flowthrough_sync_sram_port

`default_nettype wire

// [verilog/sram_core_array.sv]
// storage array with one lane-masked write port and one combinational read port
// assumes: contents are not reset, so they survive any reset or sleep
`include "sram_port_map.svh"
`default_nettype none

module sram_core_array (
   input wire logic CLK, // clock
   input wire logic wr_en, // write this edge
   input wire sram_port_pkg::word_addr_t wr_addr, // write word address
   input wire sram_port_pkg::lane_mask_t wr_lanes, // lanes to update
   input wire sram_port_pkg::word_data_t wr_data, // write data
   input wire sram_port_pkg::word_addr_t rd_addr, // read word address
   output sram_port_pkg::word_data_t rd_data // read data, combinational
);
   import sram_port_pkg::*;

   word_data_t mem [0:(1 << `ADDR_W) - 1];

   assign rd_data = mem[rd_addr];

   // ==========================================================
   // lane-masked write
   always_ff @(posedge CLK) begin
      if (wr_en && wr_lanes[0]) begin
         mem[wr_addr][`LANE_LOW_LSB +: `LANE_W] <= wr_data[`LANE_LOW_LSB +: `LANE_W];
      end
      if (wr_en && wr_lanes[1]) begin
         mem[wr_addr][`LANE_HIGH_LSB +: `LANE_W] <= wr_data[`LANE_HIGH_LSB +: `LANE_W];
      end
   end
endmodule // sram_core_array

`default_nettype wire

// [verilog/wbuf_fifo.sv]
// parameterised first-in first-out buffer, flip-flop storage
// assumes: single clock, asynchronous active-high reset
`default_nettype none

module wbuf_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 8
) (
   input wire logic CLK, // clock
   input wire logic RST, // async reset, active high
   input wire logic in_valid, // producer offers a word
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word offered
   output logic out_valid, // a word is held
   input wire logic out_ready, // consumer takes the word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [PW:0] cnt;
   } fifo_state_t;

   fifo_state_t st_q, st_d;
   logic push, pop;

   // ==========================================================
   // handshake
   assign in_ready = st_q.cnt != (PW+1)'(DEPTH);
   assign out_valid = st_q.cnt != '0;
   assign out_data = st_q.mem[st_q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // next state: pointers wrap at the depth
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wr] = in_data;
         st_d.wr = (st_q.wr == PW'(DEPTH - 1)) ? '0 : PW'(st_q.wr + 1'b1);
      end
      if (pop) begin
         st_d.rd = (st_q.rd == PW'(DEPTH - 1)) ? '0 : PW'(st_q.rd + 1'b1);
      end
      st_d.cnt = (PW+1)'(st_q.cnt + (PW+1)'(push) - (PW+1)'(pop));
   end

   // state register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // wbuf_fifo

`default_nettype wire
